// ### src/sol_prot_pkg.sv
// Shared constants and types for the solenoid channel protection logic.
package sol_prot_pkg;
  localparam int NUM_CH           = 2;
  localparam int SETPOINT_W       = 11;
  localparam int FILTER_MIN_CYC   = 20;
  localparam int FILTER_MAX_CYC   = 40;
  localparam int FILTER_CYC       = 30;
  localparam int FILTER_W         = 6;
  localparam logic [SETPOINT_W-1:0] SETPOINT_ZERO = 11'h000;
  localparam logic [FILTER_W-1:0]   FILTER_ZERO   = 6'h00;
  localparam logic [FILTER_W-1:0]   FILTER_ONE    = 6'h01;
  localparam logic CFG_LOW_SIDE  = 1'b0;
  localparam logic CFG_HIGH_SIDE = 1'b1;
  typedef enum {CH_OFF, CH_RUN, CH_TRIPPED} ch_state_t;
endpackage

// ### src/sol_sync.sv
// Two-flop synchroniser for a bus of asynchronous comparator levels.
`timescale 1ns/1ps
`default_nettype none
module sol_sync #(
  parameter int W = 1
) (
  input  wire logic         CLOCK,
  input  wire logic         SYS_RST,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ### src/sol_oc_filter.sv
// Overcurrent persistence filter counting system clock cycles.
`timescale 1ns/1ps
`default_nettype none
module sol_oc_filter
  import sol_prot_pkg::*;
#(
  parameter int FILTER_CYCLES = sol_prot_pkg::FILTER_CYC
) (
  input  wire logic CLOCK,
  input  wire logic SYS_RST,
  input  wire logic active,
  input  wire logic over_low,
  output logic      expired
);
  localparam logic [FILTER_W-1:0] LIMIT = FILTER_W'(FILTER_CYCLES);
  logic [FILTER_W-1:0] overcurrent_filter_timer;
  logic [FILTER_W-1:0] next_overcurrent_filter_timer;
  logic                next_expired;

  always_comb begin
    next_overcurrent_filter_timer = FILTER_ZERO;
    next_expired                  = 1'b0;
    if (active && over_low) begin
      if (overcurrent_filter_timer >= LIMIT) begin
        next_overcurrent_filter_timer = overcurrent_filter_timer;
        next_expired                  = 1'b1;
      end else begin
        next_overcurrent_filter_timer = overcurrent_filter_timer + FILTER_ONE;
      end
    end
    // Falling back below the low limit restarts the count from zero.
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      overcurrent_filter_timer <= FILTER_ZERO;
      expired                  <= 1'b0;
    end else begin
      overcurrent_filter_timer <= next_overcurrent_filter_timer;
      expired                  <= next_expired;
    end
  end
endmodule
`default_nettype wire

// ### src/sol_fault_protect.sv
// Two-channel solenoid driver fault protection: shutdown, fault latching and alert.
`timescale 1ns/1ps
`default_nettype none
module sol_fault_protect
  import sol_prot_pkg::*;
#(
  parameter int N             = sol_prot_pkg::NUM_CH,
  parameter int FILTER_CYCLES = sol_prot_pkg::FILTER_CYC
) (
  input  wire logic                                  CLOCK,
  input  wire logic                                  SYS_RST,
  input  wire logic [N-1:0]                          CH_CONFIG_HIGH_SIDE,
  input  wire logic [N-1:0]                          CHANNEL_FAULT_MASK,
  input  wire logic [N-1:0]                          ENABLE_WR,
  input  wire logic [N-1:0]                          ENABLE_WR_DATA,
  input  wire logic [N-1:0]                          SETPOINT_WR,
  input  wire logic [N*sol_prot_pkg::SETPOINT_W-1:0] SETPOINT_WR_DATA,
  input  wire logic                                  REPORT_READ,
  input  wire logic [N-1:0]                          OC_LOW_HS_ASYNC,
  input  wire logic [N-1:0]                          OC_LOW_LS_ASYNC,
  input  wire logic [N-1:0]                          OC_HIGH_HS_ASYNC,
  input  wire logic [N-1:0]                          OC_HIGH_LS_ASYNC,
  input  wire logic [N-1:0]                          OPEN_LOAD_ON_ASYNC,
  input  wire logic [N-1:0]                          OVER_TEMP_ASYNC,
  input  wire logic [N-1:0]                          UNDER_VOLT_ASYNC,
  input  wire logic                                  VBAT_OVER_VOLT_ASYNC,
  output logic      [N-1:0]                          CHANNEL_ENABLE,
  output logic      [N*sol_prot_pkg::SETPOINT_W-1:0] SETPOINT,
  output logic      [N-1:0]                          STAGE_ON,
  output logic      [N-1:0]                          OVERCURRENT_FLAG,
  output logic      [N-1:0]                          OPEN_LOAD_BYPASS_FLAG,
  output logic      [N-1:0]                          OVERTEMP_FLAG,
  output logic      [N-1:0]                          UNDERVOLT_FLAG,
  output logic                                       OVERVOLT_FLAG,
  output logic                                       FAULT_ALERT_OUTPUT_OUT,
  output logic                                       FAULT_ALERT_OUTPUT_OE
);
  localparam int SW = SETPOINT_W;
  localparam int CW = 7 * N + 1;

  // Every comparator level crosses into the clock domain here.
  logic [CW-1:0] cmp_sync;
  logic [N-1:0]  oc_low_hs;
  logic [N-1:0]  oc_low_ls;
  logic [N-1:0]  oc_high_hs;
  logic [N-1:0]  oc_high_ls;
  logic [N-1:0]  open_load_on;
  logic [N-1:0]  over_temp;
  logic [N-1:0]  under_volt;
  logic          over_volt;

  sol_sync #(
    .W (CW)
  ) u_sync (
    .CLOCK    (CLOCK),
    .SYS_RST  (SYS_RST),
    .async_in ({VBAT_OVER_VOLT_ASYNC, UNDER_VOLT_ASYNC, OVER_TEMP_ASYNC,
                OPEN_LOAD_ON_ASYNC, OC_HIGH_LS_ASYNC, OC_HIGH_HS_ASYNC,
                OC_LOW_LS_ASYNC, OC_LOW_HS_ASYNC}),
    .sync_out (cmp_sync)
  );

  assign {over_volt, under_volt, over_temp, open_load_on,
          oc_high_ls, oc_high_hs, oc_low_ls, oc_low_hs} = cmp_sync;

  // Channel running means enabled with a nonzero setpoint.
  function automatic logic is_running(input logic en, input logic [SW-1:0] sp);
    is_running = en && (sp != SETPOINT_ZERO);
  endfunction

  // Picks one channel's setpoint field out of the packed vector.
  function automatic logic [SW-1:0] sp_field(input logic [N*SW-1:0] vec, input int ch);
    sp_field = vec[ch*SW +: SW];
  endfunction

  // Any of these conditions forces the channel off. Open load only counts while
  // the stage is driven, since an idle channel draws no current to judge.
  function automatic logic fault_kill(input logic same, input logic opp,
                                      input logic open_drv, input logic hot,
                                      input logic low_supply, input logic high_vbat);
    fault_kill = same || opp || open_drv || hot || low_supply || high_vbat;
  endfunction

  logic [N-1:0] filt_hs;
  logic [N-1:0] filt_ls;

  // Each switch has its own filter so that a slow trip is blamed on the right side.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      sol_oc_filter #(
        .FILTER_CYCLES (FILTER_CYCLES)
      ) u_filt_hs (
        .CLOCK    (CLOCK),
        .SYS_RST  (SYS_RST),
        .active   (STAGE_ON[g]),
        .over_low (oc_low_hs[g]),
        .expired  (filt_hs[g])
      );
      sol_oc_filter #(
        .FILTER_CYCLES (FILTER_CYCLES)
      ) u_filt_ls (
        .CLOCK    (CLOCK),
        .SYS_RST  (SYS_RST),
        .active   (STAGE_ON[g]),
        .over_low (oc_low_ls[g]),
        .expired  (filt_ls[g])
      );
    end
  endgenerate

  // Decoded trip causes per channel, shared by the flag group and the channel group.
  logic [N-1:0] same_side;
  logic [N-1:0] opp_side;
  logic [N-1:0] open_on;
  logic [N-1:0] kill;

  always_comb begin
    logic hs_trip;
    logic ls_trip;
    hs_trip   = 1'b0;
    ls_trip   = 1'b0;
    same_side = '0;
    opp_side  = '0;
    open_on   = '0;
    kill      = '0;
    for (int i = 0; i < N; i++) begin
      // High limit trips at once; low limit only via the expired filter.
      hs_trip = STAGE_ON[i] && (oc_high_hs[i] || filt_hs[i]);
      ls_trip = STAGE_ON[i] && (oc_high_ls[i] || filt_ls[i]);
      if (CH_CONFIG_HIGH_SIDE[i] == CFG_HIGH_SIDE) begin
        same_side[i] = hs_trip;
        opp_side[i]  = ls_trip;
      end else begin
        same_side[i] = ls_trip;
        opp_side[i]  = hs_trip;
      end
      open_on[i] = STAGE_ON[i] && open_load_on[i];
      kill[i]    = fault_kill(same_side[i], opp_side[i], open_on[i], over_temp[i],
                              under_volt[i], over_volt);
    end
  end

  logic [N-1:0] next_oc_flag;
  logic [N-1:0] next_open_load_bypass_flag_flag;
  logic [N-1:0] next_ot_flag;
  logic [N-1:0] next_uv_flag;
  logic         next_ov_flag;

  // Clears are applied first so that a fault arriving in the same cycle wins.
  always_comb begin
    next_oc_flag   = OVERCURRENT_FLAG;
    next_open_load_bypass_flag_flag = OPEN_LOAD_BYPASS_FLAG;
    next_ot_flag   = OVERTEMP_FLAG;
    next_uv_flag   = UNDERVOLT_FLAG;
    next_ov_flag   = OVERVOLT_FLAG;
    if (REPORT_READ) begin
      next_oc_flag = '0;
      next_ov_flag = over_volt;
      for (int i = 0; i < N; i++) begin
        if (!over_temp[i]) next_ot_flag[i] = 1'b0;
        if (!open_load_on[i]) next_open_load_bypass_flag_flag[i] = 1'b0;
        if (!under_volt[i]) next_uv_flag[i] = 1'b0;
      end
    end
    next_oc_flag   = next_oc_flag | same_side;
    next_open_load_bypass_flag_flag = next_open_load_bypass_flag_flag | opp_side | open_on;
    next_ot_flag   = next_ot_flag | over_temp;
    next_uv_flag   = next_uv_flag | under_volt;
    if (over_volt) next_ov_flag = 1'b1;
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      OVERCURRENT_FLAG      <= '0;
      OPEN_LOAD_BYPASS_FLAG <= '0;
      OVERTEMP_FLAG         <= '0;
      UNDERVOLT_FLAG        <= '0;
      OVERVOLT_FLAG         <= 1'b0;
    end else begin
      OVERCURRENT_FLAG      <= next_oc_flag;
      OPEN_LOAD_BYPASS_FLAG <= next_open_load_bypass_flag_flag;
      OVERTEMP_FLAG         <= next_ot_flag;
      UNDERVOLT_FLAG        <= next_uv_flag;
      OVERVOLT_FLAG         <= next_ov_flag;
    end
  end

  // A channel is idle, driving, or tripped and waiting for the host. The pending
  // bit stays set from the trip until the report is read, so that a write racing
  // the read cannot restart the channel early.
  ch_state_t       state [N];
  ch_state_t       next_state [N];
  logic [N-1:0]    next_enable;
  logic [N*SW-1:0] next_setpoint;
  logic [N-1:0]    next_stage_on;
  logic [N-1:0]    next_report_pending;
  logic [N-1:0]    report_pending;
  logic            alert;

  always_comb begin
    next_state          = state;
    next_enable         = CHANNEL_ENABLE;
    next_setpoint       = SETPOINT;
    next_stage_on       = '0;
    next_report_pending = report_pending;
    if (REPORT_READ) next_report_pending = '0;
    for (int i = 0; i < N; i++) begin
      if (ENABLE_WR[i]) next_enable[i] = ENABLE_WR_DATA[i];
      if (SETPOINT_WR[i]) next_setpoint[i*SW +: SW] = SETPOINT_WR_DATA[i*SW +: SW];

      case (state[i])
        CH_OFF: begin
          if (!kill[i] && is_running(next_enable[i], sp_field(next_setpoint, i))) begin
            next_state[i]    = CH_RUN;
            next_stage_on[i] = 1'b1;
          end
        end
        CH_RUN: begin
          next_stage_on[i] = is_running(next_enable[i], sp_field(next_setpoint, i));
          if (!next_stage_on[i]) next_state[i] = CH_OFF;
        end
        CH_TRIPPED: begin
          // A fresh enable and nonzero setpoint after the report read restarts.
          if (!report_pending[i] && !kill[i]
              && is_running(next_enable[i], sp_field(next_setpoint, i))) begin
            next_state[i]    = CH_RUN;
            next_stage_on[i] = 1'b1;
          end
        end
        default: next_state[i] = CH_OFF;
      endcase

      if (kill[i]) begin
        // Stage off and control bits cleared, overriding any same-cycle write.
        next_state[i]              = CH_TRIPPED;
        next_stage_on[i]           = 1'b0;
        next_enable[i]             = 1'b0;
        next_setpoint[i*SW +: SW]  = SETPOINT_ZERO;
        next_report_pending[i]     = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state          <= '{default: CH_OFF};
      CHANNEL_ENABLE <= '0;
      SETPOINT       <= '0;
      STAGE_ON       <= '0;
      report_pending <= '0;
    end else begin
      state          <= next_state;
      CHANNEL_ENABLE <= next_enable;
      SETPOINT       <= next_setpoint;
      STAGE_ON       <= next_stage_on;
      report_pending <= next_report_pending;
    end
  end

  // Unmasked channel flags and the overvoltage flag pull the wired-AND alert low.
  // Overvoltage has no mask of its own: it stops every channel, so the host must
  // always hear of it.
  always_comb begin
    alert = OVERVOLT_FLAG;
    for (int i = 0; i < N; i++) begin
      alert = alert || (CHANNEL_FAULT_MASK[i] && (OVERCURRENT_FLAG[i]
              || OPEN_LOAD_BYPASS_FLAG[i] || OVERTEMP_FLAG[i] || UNDERVOLT_FLAG[i]));
    end
  end

  // Open drain: the pin is only ever driven low, never high.
  assign FAULT_ALERT_OUTPUT_OUT = 1'b0;
  assign FAULT_ALERT_OUTPUT_OE  = alert;
endmodule
`default_nettype wire

// ### tb/sol_fault_protect_properties.sv
// Port-level assertions for the solenoid channel fault protection block.
`timescale 1ns/1ps
`default_nettype none
module sol_fault_protect_properties #(
  parameter int N = 2
) (
  input wire logic                                  CLOCK,
  input wire logic                                  SYS_RST,
  input wire logic [N-1:0]                          CHANNEL_FAULT_MASK,
  input wire logic                                  REPORT_READ,
  input wire logic [N-1:0]                          OC_LOW_HS_ASYNC,
  input wire logic [N-1:0]                          OC_LOW_LS_ASYNC,
  input wire logic [N-1:0]                          OC_HIGH_HS_ASYNC,
  input wire logic [N-1:0]                          OC_HIGH_LS_ASYNC,
  input wire logic [N-1:0]                          OPEN_LOAD_ON_ASYNC,
  input wire logic                                  VBAT_OVER_VOLT_ASYNC,
  input wire logic [N-1:0]                          CHANNEL_ENABLE,
  input wire logic [N*sol_prot_pkg::SETPOINT_W-1:0] SETPOINT,
  input wire logic [N-1:0]                          STAGE_ON,
  input wire logic [N-1:0]                          OVERCURRENT_FLAG,
  input wire logic [N-1:0]                          OPEN_LOAD_BYPASS_FLAG,
  input wire logic [N-1:0]                          OVERTEMP_FLAG,
  input wire logic [N-1:0]                          UNDERVOLT_FLAG,
  input wire logic                                  OVERVOLT_FLAG,
  input wire logic                                  FAULT_ALERT_OUTPUT_OUT,
  input wire logic                                  FAULT_ALERT_OUTPUT_OE
);
  import sol_prot_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  logic quiet;
  assign quiet = ~|{OC_LOW_HS_ASYNC, OC_LOW_LS_ASYNC, OC_HIGH_HS_ASYNC, OC_HIGH_LS_ASYNC,
                    OPEN_LOAD_ON_ASYNC};
  alert_map_a: assert property (
    FAULT_ALERT_OUTPUT_OE == (OVERVOLT_FLAG || |(CHANNEL_FAULT_MASK & (OVERCURRENT_FLAG |
    OPEN_LOAD_BYPASS_FLAG | OVERTEMP_FLAG | UNDERVOLT_FLAG))) && !FAULT_ALERT_OUTPUT_OUT)
    else $error("Alert pin does not follow the unmasked flags.");
  ov_off_a: assert property (
    VBAT_OVER_VOLT_ASYNC [*4] |-> STAGE_ON == '0 && CHANNEL_ENABLE == '0 && SETPOINT == '0)
    else $error("Channels still driven during overvoltage.");
  ov_sticky_a: assert property (
    OVERVOLT_FLAG && !REPORT_READ |=> OVERVOLT_FLAG)
    else $error("Overvoltage flag dropped without a read.");
  ov_read_hold_a: assert property (
    VBAT_OVER_VOLT_ASYNC [*3] ##0 (OVERVOLT_FLAG && REPORT_READ) |=> OVERVOLT_FLAG)
    else $error("Overvoltage flag cleared while the condition lasts.");
  ot_sticky_a: assert property (
    !REPORT_READ |=> (OVERTEMP_FLAG & $past(OVERTEMP_FLAG)) == $past(OVERTEMP_FLAG))
    else $error("Overtemperature flag dropped without a read.");
  report_clear_a: assert property (
    quiet [*4] ##0 REPORT_READ |=> OVERCURRENT_FLAG == '0 && OPEN_LOAD_BYPASS_FLAG == '0)
    else $error("Overcurrent flag survived a report read.");
  for (genvar i = 0; i < N; i++) begin : g_ch
    // Counts cycles a low-limit overcurrent is seen while the stage is still driven.
    logic [5:0] cnt;
    always_ff @(posedge CLOCK) begin
      if (SYS_RST || !STAGE_ON[i] || !(OC_LOW_HS_ASYNC[i] || OC_LOW_LS_ASYNC[i])) begin
        cnt <= 6'h00;
      end else if (cnt != 6'h3f) begin
        cnt <= cnt + 6'h01;
      end
    end
    stage_gate_a: assert property (
      STAGE_ON[i] |-> CHANNEL_ENABLE[i] && SETPOINT[i*SETPOINT_W +: SETPOINT_W] != '0)
      else $error("Stage driven without enable and setpoint.");
    quick_trip_a: assert property (
      (OC_HIGH_HS_ASYNC[i] || OC_HIGH_LS_ASYNC[i]) [*4] |-> !STAGE_ON[i] && !CHANNEL_ENABLE[i])
      else $error("High-limit overcurrent did not stop the stage.");
    filter_bound_a: assert property (cnt <= 6'h2b)
      else $error("Low-limit overcurrent outlasted the filter.");
  end
  cover property ($fell(STAGE_ON[0]));
  cover property (REPORT_READ && OVERVOLT_FLAG);
  cover property (REPORT_READ && OVERTEMP_FLAG != '0);
endmodule
`default_nettype wire

// ### tb/sol_host_model.sv
// Host controller model that writes enables and setpoints and reads the fault report.
`timescale 1ns/1ps
`default_nettype none
module sol_host_model (
  input  wire logic                                                    CLOCK,
  output logic      [sol_prot_pkg::NUM_CH-1:0]                         ENABLE_WR,
  output logic      [sol_prot_pkg::NUM_CH-1:0]                         ENABLE_WR_DATA,
  output logic      [sol_prot_pkg::NUM_CH-1:0]                         SETPOINT_WR,
  output logic      [sol_prot_pkg::NUM_CH*sol_prot_pkg::SETPOINT_W-1:0] SETPOINT_WR_DATA,
  output logic                                                         REPORT_READ
);
  import sol_prot_pkg::*;
  initial begin
    {ENABLE_WR, ENABLE_WR_DATA, SETPOINT_WR, SETPOINT_WR_DATA, REPORT_READ} = '0;
  end
  // Re-arming always sets enable and a nonzero setpoint together; data lines are
  // inverted afterwards so a stale value is never mistaken for a fresh write.
  task automatic arm(input int ch, input logic [SETPOINT_W-1:0] sp);
    ENABLE_WR[ch] = 1'b1;
    ENABLE_WR_DATA[ch] = 1'b1;
    SETPOINT_WR[ch] = 1'b1;
    SETPOINT_WR_DATA[ch*SETPOINT_W +: SETPOINT_W] = sp;
    @(posedge CLOCK);
    #1;
    {ENABLE_WR, SETPOINT_WR} = '0;
    ENABLE_WR_DATA = ~ENABLE_WR_DATA;
    SETPOINT_WR_DATA = ~SETPOINT_WR_DATA;
  endtask
  task automatic read_report();
    REPORT_READ = 1'b1;
    @(posedge CLOCK);
    #1;
    REPORT_READ = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/sol_fault_protect_bench.sv
// Self-checking bench for the solenoid channel fault protection block.
`timescale 1ns/1ps
`default_nettype none
module sol_fault_protect_bench;
  import sol_prot_pkg::*;
  logic CLOCK, SYS_RST, REPORT_READ, VBAT_OVER_VOLT_ASYNC, OVERVOLT_FLAG;
  logic FAULT_ALERT_OUTPUT_OUT, FAULT_ALERT_OUTPUT_OE;
  logic [1:0] CH_CONFIG_HIGH_SIDE, CHANNEL_FAULT_MASK, ENABLE_WR, ENABLE_WR_DATA, SETPOINT_WR;
  logic [1:0] OC_LOW_HS_ASYNC, OC_LOW_LS_ASYNC, OC_HIGH_HS_ASYNC, OC_HIGH_LS_ASYNC;
  logic [1:0] OPEN_LOAD_ON_ASYNC, OVER_TEMP_ASYNC, UNDER_VOLT_ASYNC, CHANNEL_ENABLE, STAGE_ON;
  logic [1:0] OVERCURRENT_FLAG, OPEN_LOAD_BYPASS_FLAG, OVERTEMP_FLAG, UNDERVOLT_FLAG;
  logic [2*SETPOINT_W-1:0] SETPOINT_WR_DATA, SETPOINT;
  logic [SETPOINT_W-1:0]   sp;
  int                      fails, n_checks, seed, ch, t;
  sol_fault_protect uut (.*);
  sol_host_model host (.*);
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s: got %0h expected %0h", $time, msg, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) begin
      @(posedge CLOCK);
      #1;
    end
  endtask
  function automatic logic [SETPOINT_W-1:0] rand_sp();
    return 11'($unsigned($random(seed)) % 2047) + 11'h001;
  endfunction
  // Same-side switch reports overcurrent, opposite side reports open load or bypass.
  function automatic logic [1:0] exp_flags(input bit cfg, input bit site);
    return {site == cfg, site != cfg};
  endfunction
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    test_done();
  end
  initial begin
    seed = 14061;
    {CH_CONFIG_HIGH_SIDE, CHANNEL_FAULT_MASK, OC_LOW_HS_ASYNC, OC_LOW_LS_ASYNC} = '0;
    {OC_HIGH_HS_ASYNC, OC_HIGH_LS_ASYNC, OPEN_LOAD_ON_ASYNC, OVER_TEMP_ASYNC} = '0;
    {UNDER_VOLT_ASYNC, VBAT_OVER_VOLT_ASYNC} = '0;
    SYS_RST = 1'b1;
    step(5);
    SYS_RST = 1'b0;
    CHANNEL_FAULT_MASK = 2'h3;
    for (bit [2:0] k = 0; k < 7; k++) begin
      ch = k[0];
      CH_CONFIG_HIGH_SIDE[ch] = k[1];
      sp = rand_sp();
      host.arm(ch, sp);
      chk({STAGE_ON[ch], CHANNEL_ENABLE[ch], SETPOINT[ch*11 +: 11]}, {2'h3, sp}, "arm");
      if (k[2]) OC_HIGH_HS_ASYNC[ch] = 1'b1;
      else OC_HIGH_LS_ASYNC[ch] = 1'b1;
      step(4);
      chk({STAGE_ON[ch], CHANNEL_ENABLE[ch], SETPOINT[ch*11 +: 11]}, 0, "trip");
      chk({OVERCURRENT_FLAG[ch], OPEN_LOAD_BYPASS_FLAG[ch]}, exp_flags(k[1], k[2]), "map");
      chk(FAULT_ALERT_OUTPUT_OE, 1, "alert");
      {OC_HIGH_HS_ASYNC, OC_HIGH_LS_ASYNC} = '0;
      host.arm(ch, sp);
      chk(STAGE_ON[ch], 0, "rearm before read");
      step(2);
      host.read_report();
      chk({OVERCURRENT_FLAG[ch], OPEN_LOAD_BYPASS_FLAG[ch]}, 0, "read clears");
      host.arm(ch, sp);
      chk(STAGE_ON[ch], 1, "restart");
    end
    $display("Quick shutoff test done");
    ch = $unsigned($random(seed)) % 2;
    repeat (2) begin
      OC_LOW_LS_ASYNC[ch] = 1'b1;
      step(FILTER_MIN_CYC - 2);
      OC_LOW_LS_ASYNC[ch] = 1'b0;
      step(4);
    end
    chk(STAGE_ON[ch], 1, "short pulses");
    OC_LOW_LS_ASYNC[ch] = 1'b1;
    t = 0;
    while (STAGE_ON[ch] === 1'b1 && t < 60) begin
      step(1);
      t++;
    end
    chk(t > FILTER_MIN_CYC && t <= FILTER_MAX_CYC + 3, 1, "filter time");
    OC_LOW_LS_ASYNC[ch] = 1'b0;
    step(3);
    host.read_report();
    $display("Filter test done");
    CHANNEL_FAULT_MASK = 2'h0;
    host.arm(ch, rand_sp());
    OVER_TEMP_ASYNC[ch] = 1'b1;
    step(4);
    chk({STAGE_ON[ch], CHANNEL_ENABLE[ch], OVERTEMP_FLAG[ch], FAULT_ALERT_OUTPUT_OE}, 2, "hot");
    CHANNEL_FAULT_MASK[ch] = 1'b1;
    step(1);
    chk(FAULT_ALERT_OUTPUT_OE, 1, "unmasked");
    host.read_report();
    chk(OVERTEMP_FLAG[ch], 1, "read while hot");
    OVER_TEMP_ASYNC[ch] = 1'b0;
    step(3);
    host.arm(ch, rand_sp());
    chk(STAGE_ON[ch], 0, "cool but unread");
    host.read_report();
    chk(OVERTEMP_FLAG[ch], 0, "cooled read");
    host.arm(ch, rand_sp());
    chk(STAGE_ON[ch], 1, "hot restart");
    $display("Overtemperature test done");
    CHANNEL_FAULT_MASK = 2'h0;
    host.arm(1 - ch, rand_sp());
    VBAT_OVER_VOLT_ASYNC = 1'b1;
    step(4);
    chk({STAGE_ON, CHANNEL_ENABLE, OVERVOLT_FLAG, FAULT_ALERT_OUTPUT_OE}, 3, "overvolt");
    chk(SETPOINT, 0, "overvolt setpoints");
    host.read_report();
    chk(OVERVOLT_FLAG, 1, "read during overvolt");
    VBAT_OVER_VOLT_ASYNC = 1'b0;
    step(3);
    host.arm(0, rand_sp());
    chk(STAGE_ON[0], 0, "unread restart");
    host.read_report();
    chk(OVERVOLT_FLAG, 0, "overvolt cleared");
    host.arm(0, rand_sp());
    chk(STAGE_ON[0], 1, "overvolt restart");
    $display("Overvoltage test done");
    OPEN_LOAD_ON_ASYNC[0] = 1'b1;
    UNDER_VOLT_ASYNC[1] = 1'b1;
    step(4);
    chk({STAGE_ON[0], OPEN_LOAD_BYPASS_FLAG[0], OVERCURRENT_FLAG[0]}, 2, "open load");
    chk({UNDERVOLT_FLAG[1], FAULT_ALERT_OUTPUT_OE}, 2, "masked undervolt");
    host.read_report();
    chk({OPEN_LOAD_BYPASS_FLAG[0], UNDERVOLT_FLAG[1]}, 3, "read while present");
    {OPEN_LOAD_ON_ASYNC, UNDER_VOLT_ASYNC} = '0;
    step(3);
    host.read_report();
    chk({OPEN_LOAD_BYPASS_FLAG[0], UNDERVOLT_FLAG[1]}, 0, "open load cleared");
    $display("Open load test done");
    test_done();
  end
endmodule
bind sol_fault_protect sol_fault_protect_properties #(.N(N)) props (.*);
`default_nettype wire
